// ---- src/thread_regs_pkg.sv ----
// Package of constants and carrier types for the per-thread special registers
package thread_regs_pkg;

    // ************************************************************
    // Register space encodings
    // ************************************************************
    localparam logic [3:0] TYPE_NOTIFY  = 4'h9;  // Notification register group
    localparam logic [3:0] TYPE_IP      = 4'hA;  // Instruction pointer group
    localparam logic [3:0] TYPE_PERF    = 4'hC;  // Timestamp, counter, pause group
    localparam logic [3:0] NUM_HOST     = 4'h1;  // Host notification register number
    localparam logic [3:0] NUM_ZERO     = 4'h0;
    localparam logic [4:0] SUB_DW0      = 5'h00;
    localparam logic [4:0] SUB_DW1      = 5'h04;
    localparam logic [4:0] SUB_DW2      = 5'h08;
    localparam logic [4:0] SUB_DW3      = 5'h0C;
    localparam logic [4:0] SUB_DW4      = 5'h10;

    // ************************************************************
    // Field layouts and reset values
    // ************************************************************
    localparam int         IP_LOW_BITS  = 3;       // Pointer lives in bits 31:3
    localparam int         PAUSE_LSB    = 5;       // Count field bits 9:5
    localparam int         PAUSE_WIDTH  = 5;
    localparam logic [31:0] HOST_RESET  = 32'h0000_0000;
    localparam logic [31:0] IP_RESET    = 32'h0000_0000;
    localparam logic [31:0] PERF_RESET  = 32'h0000_0000;
    localparam logic [63:0] TS_RESET    = 64'h0000_0000_0000_0000;

    // ************************************************************
    // Timing counts
    // ************************************************************
    localparam int         PAUSE_STEP_CLOCKS = 32;  // One count-field step per 32 clocks
    localparam int         PRESCALE_BITS     = 5;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic [3:0] reg_type;
        logic [3:0] reg_num;
        logic [4:0] sub_num;
    } arf_addr_type;

    typedef struct packed {
        logic        discontinuity;
        logic [31:0] upper_half;
        logic [31:0] lower_half;
    } ts_snapshot_type;

endpackage

// ---- src/timestamp_counter.sv ----
// Free-running 64-bit timestamp counter advanced by a synchronised tick pin
`timescale 1ns/1ps
module timestamp_counter
    import thread_regs_pkg::*;
#(
    parameter int WIDTH = 64
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             tick_pin,
    output logic [WIDTH-1:0]      count
);

    // ************************************************************
    // Tick synchroniser
    // ************************************************************
    logic tick_meta_reg;
    logic tick_sync_reg;
    logic tick_last_reg;

    // Two stages before use; the second stage and a third delayed copy form a rising-edge detect
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tick_meta_reg <= 1'b0;
            tick_sync_reg <= 1'b0;
            tick_last_reg <= 1'b0;
        end
        else
        begin
            tick_meta_reg <= tick_pin;
            tick_sync_reg <= tick_meta_reg;
            tick_last_reg <= tick_sync_reg;
        end
    end

    // ************************************************************
    // Counter
    // ************************************************************
    // No load path at all: nothing but reset can move the count back
    always_ff @(posedge clk)
    begin
        if (rst)
            count <= WIDTH'(TS_RESET);
        else if (tick_sync_reg && !tick_last_reg)
            count <= count + WIDTH'(1);
    end

endmodule

// ---- src/pause_countdown.sv ----
// Self-pause countdown with a free-running 32-clock step prescaler
`timescale 1ns/1ps
module pause_countdown
    import thread_regs_pkg::*;
#(
    parameter int FIELD_WIDTH = PAUSE_WIDTH
)
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   load_en,
    input  wire logic [FIELD_WIDTH-1:0] load_field,
    input  wire logic                   retire,
    input  wire logic                   clear,
    output logic [FIELD_WIDTH-1:0]      field,
    output logic                        busy
);

    // ************************************************************
    // Prescaler
    // ************************************************************
    logic [PRESCALE_BITS-1:0] prescale_reg;
    logic                     armed_reg;
    logic                     step;

    // Free-running, so the first step lands 1 to 32 clocks after retire
    always_ff @(posedge clk)
    begin
        if (rst)
            prescale_reg <= '0;
        else
            prescale_reg <= prescale_reg + PRESCALE_BITS'(1);
    end

    assign step = (prescale_reg == PRESCALE_BITS'(PAUSE_STEP_CLOCKS - 1));

    // ************************************************************
    // Count field
    // ************************************************************
    // Clear beats load; countdown only while armed and nonzero
    always_ff @(posedge clk)
    begin
        if (rst || clear)
            field <= '0;
        else if (load_en)
            field <= load_field;
        else if (armed_reg && step && field != '0)
            field <= field - FIELD_WIDTH'(1);
    end

    // Armed by the retirement of the writing instruction, not its issue
    always_ff @(posedge clk)
    begin
        if (rst || clear || load_en)
            armed_reg <= 1'b0;
        else if (retire)
            armed_reg <= 1'b1;
        else if (field == '0)
            armed_reg <= 1'b0;
    end

    assign busy = (field != '0);

endmodule

// ---- src/thread_special_registers.sv ----
// Per-thread special register file: notify, pointer, timestamp, counter, pause
`timescale 1ns/1ps
module thread_special_registers
    import thread_regs_pkg::*;
#(
    parameter int TS_WIDTH   = 64,
    parameter int PERF_WIDTH = 32
)
(
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Register read port from the issue pipeline
    input  wire logic                    rd_en,
    input  wire thread_regs_pkg::arf_addr_type rd_addr,
    output logic                         rd_valid,
    output logic [31:0]                  rd_data,
    output thread_regs_pkg::ts_snapshot_type ts_snapshot,
    // Register write port from the execution pipeline
    input  wire logic                    wr_en,
    input  wire thread_regs_pkg::arf_addr_type wr_addr,
    input  wire logic [31:0]             wr_data,
    input  wire logic                    pause_write_retire,
    // Instruction pointer tracking
    input  wire logic                    ip_update_en,
    input  wire logic [31:0]             ip_update_val,
    input  wire logic [31:0]             dispatch_ip,
    output logic                         redirect_valid,
    output logic [31:0]                  redirect_addr,
    // Thread and context events
    input  wire logic                    thread_load,
    input  wire logic                    sip_invoke,
    input  wire logic                    ctx_save_begin,
    input  wire logic                    ctx_restore_begin,
    input  wire logic                    ctx_save_active,
    input  wire logic                    ctx_restore_active,
    input  wire logic                    time_event,
    // Host notification
    input  wire logic                    host_notify_set,
    input  wire logic                    host_notify_consume,
    // Timestamp tick pin and performance event
    input  wire logic                    ts_tick_pin,
    input  wire logic                    perf_event,
    // Issue gate
    output logic                         issue_block
);

    // ************************************************************
    // Address decode
    // ************************************************************
    logic rd_host;
    logic rd_ip;
    logic rd_perf;
    logic rd_ts;
    logic wr_host;
    logic wr_ip;
    logic wr_pause;

    // Read decode per register
    always_comb
    begin
        rd_host = rd_en && rd_addr.reg_type == TYPE_NOTIFY
                  && rd_addr.reg_num == NUM_HOST && rd_addr.sub_num == SUB_DW0;
        rd_ip   = rd_en && rd_addr.reg_type == TYPE_IP
                  && rd_addr.reg_num == NUM_ZERO && rd_addr.sub_num == SUB_DW0;
        rd_perf = rd_en && rd_addr.reg_type == TYPE_PERF
                  && rd_addr.reg_num == NUM_ZERO;
        rd_ts   = rd_perf && (rd_addr.sub_num == SUB_DW0
                  || rd_addr.sub_num == SUB_DW1 || rd_addr.sub_num == SUB_DW2);
    end

    // Write decode; the timestamp and counter dwords have no write decode
    always_comb
    begin
        wr_host  = wr_en && ctx_restore_active && wr_addr.reg_type == TYPE_NOTIFY
                   && wr_addr.reg_num == NUM_HOST && wr_addr.sub_num == SUB_DW0;
        wr_ip    = wr_en && wr_addr.reg_type == TYPE_IP
                   && wr_addr.reg_num == NUM_ZERO && wr_addr.sub_num == SUB_DW0;
        // Restore traffic must not reload a pause
        wr_pause = wr_en && !ctx_restore_active && wr_addr.reg_type == TYPE_PERF
                   && wr_addr.reg_num == NUM_ZERO && wr_addr.sub_num == SUB_DW4;
    end

    // ************************************************************
    // Host notification flag
    // ************************************************************
    logic host_flag_reg;

    // Host set wins over a same-cycle consume
    always_ff @(posedge clk)
    begin
        if (rst)
            host_flag_reg <= HOST_RESET[0];
        else if (host_notify_set)
            host_flag_reg <= 1'b1;
        else if (wr_host)
            host_flag_reg <= wr_data[0];
        else if (host_notify_consume)
            host_flag_reg <= 1'b0;
    end

    // ************************************************************
    // Instruction pointer
    // ************************************************************
    logic [31:IP_LOW_BITS] ip_reg;
    logic [31:IP_LOW_BITS] ip_next;

    // Dispatch first, then software redirect, then normal advance
    always_comb
    begin
        ip_next = ip_reg;
        if (thread_load)
            ip_next = dispatch_ip[31:IP_LOW_BITS];
        else if (wr_ip)
            ip_next = wr_data[31:IP_LOW_BITS];
        else if (ip_update_en)
            ip_next = ip_update_val[31:IP_LOW_BITS];
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            ip_reg <= IP_RESET[31:IP_LOW_BITS];
        else
            ip_reg <= ip_next;
    end

    // Redirect pulse; the fetch side relies on a thread switch after it
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            redirect_valid <= 1'b0;
            redirect_addr  <= 32'h0000_0000;
        end
        else
        begin
            redirect_valid <= wr_ip && !thread_load;
            redirect_addr  <= {wr_data[31:IP_LOW_BITS], IP_LOW_BITS'(0)};
        end
    end

    // ************************************************************
    // Timestamp and discontinuity flag
    // ************************************************************
    logic [TS_WIDTH-1:0] ts_count;
    logic                ts_flag_reg;

    timestamp_counter #(
        .WIDTH    (TS_WIDTH)
    ) u_timestamp (
        .clk      (clk),
        .rst      (rst),
        .tick_pin (ts_tick_pin),
        .count    (ts_count)
    );

    // Events and restore win over a same-cycle read or load clear
    always_ff @(posedge clk)
    begin
        if (rst)
            ts_flag_reg <= 1'b0;
        else if (time_event || ctx_restore_begin)
            ts_flag_reg <= 1'b1;
        else if (thread_load || rd_ts)
            ts_flag_reg <= 1'b0;
    end

    // Coherent capture of time and flag on any timestamp read
    always_ff @(posedge clk)
    begin
        if (rst)
            ts_snapshot <= '0;
        else if (rd_ts)
        begin
            ts_snapshot.discontinuity <= ts_flag_reg;
            ts_snapshot.upper_half    <= ts_count[63:32];
            ts_snapshot.lower_half    <= ts_count[31:0];
        end
    end

    // ************************************************************
    // Performance event counter
    // ************************************************************
    logic [PERF_WIDTH-1:0] perf_count_reg;

    // Deliberately blind to load, switch and write: only reset touches it
    always_ff @(posedge clk)
    begin
        if (rst)
            perf_count_reg <= PERF_WIDTH'(PERF_RESET);
        else if (perf_event)
            perf_count_reg <= perf_count_reg + PERF_WIDTH'(1);
    end

    // ************************************************************
    // Pause register
    // ************************************************************
    logic [PAUSE_WIDTH-1:0] pause_field;
    logic                   pause_busy;
    logic                   pause_clear;

    assign pause_clear = thread_load || sip_invoke
                         || ctx_save_begin || ctx_restore_begin;

    pause_countdown #(
        .FIELD_WIDTH (PAUSE_WIDTH)
    ) u_pause (
        .clk         (clk),
        .rst         (rst),
        .load_en     (wr_pause),
        .load_field  (wr_data[PAUSE_LSB +: PAUSE_WIDTH]),
        .retire      (pause_write_retire),
        .clear       (pause_clear),
        .field       (pause_field),
        .busy        (pause_busy)
    );

    // Gates only new issue; in-flight work and messages drain untouched
    assign issue_block = pause_busy;

    // ************************************************************
    // Read data path
    // ************************************************************
    logic [31:0] rd_mux;

    // Unmapped and reserved encodings return zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (rd_host)
            rd_mux = {31'h0000_0000, host_flag_reg};
        else if (rd_ip)
            rd_mux = {ip_reg, IP_LOW_BITS'(0)};
        else if (rd_perf)
        begin
            case (rd_addr.sub_num)
                SUB_DW0: rd_mux = ts_count[31:0];
                SUB_DW1: rd_mux = ts_count[63:32];
                SUB_DW2: rd_mux = {31'h0000_0000, ts_flag_reg};
                SUB_DW3: rd_mux = perf_count_reg;
                // Save sees zero so the pause never lands in saved state
                SUB_DW4: rd_mux = ctx_save_active ? 32'h0000_0000
                                  : {22'h00_0000, pause_field, 5'h00};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // Fixed one-cycle latency for every read
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rd_valid <= 1'b0;
            rd_data  <= 32'h0000_0000;
        end
        else
        begin
            rd_valid <= rd_en;
            rd_data  <= rd_mux;
        end
    end

endmodule

// ---- dv/thread_regs_monitor.sv ----
// Concurrent checks on the special register file ports
`timescale 1ns/1ps
module thread_regs_monitor
    import thread_regs_pkg::*;
(
    input wire logic                          clk,
    input wire logic                          rst,
    input wire logic                          rd_en,
    input wire thread_regs_pkg::arf_addr_type rd_addr,
    input wire logic                          rd_valid,
    input wire logic [31:0]                   rd_data,
    input wire thread_regs_pkg::ts_snapshot_type ts_snapshot,
    input wire logic                          wr_en,
    input wire thread_regs_pkg::arf_addr_type wr_addr,
    input wire logic [31:0]                   wr_data,
    input wire logic                          redirect_valid,
    input wire logic [31:0]                   redirect_addr,
    input wire logic                          thread_load,
    input wire logic                          sip_invoke,
    input wire logic                          ctx_save_begin,
    input wire logic                          ctx_restore_begin,
    input wire logic                          ctx_restore_active,
    input wire logic                          issue_block
);
    // ********
    // Decodes
    // ********
    localparam arf_addr_type A_IP = '{TYPE_IP, NUM_ZERO, SUB_DW0};
    localparam arf_addr_type A_LO = '{TYPE_PERF, NUM_ZERO, SUB_DW0};
    localparam arf_addr_type A_EVT = '{TYPE_PERF, NUM_ZERO, SUB_DW2};
    localparam arf_addr_type A_PAUSE = '{TYPE_PERF, NUM_ZERO, SUB_DW4};
    logic clr;
    // Any event that wipes the pause count
    assign clr = thread_load | sip_invoke | ctx_save_begin | ctx_restore_begin;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // ********
    // Assertions
    // ********
    a_read_answer: assert property (rd_en |=> rd_valid)
        else $error("read not answered next cycle");
    a_valid_cause: assert property (rd_valid |-> $past(rd_en))
        else $error("read valid without request");
    a_ip_redirect: assert property (wr_en && wr_addr == A_IP && !thread_load |=>
        redirect_valid && redirect_addr == ($past(wr_data) & 32'hFFFF_FFF8))
        else $error("pointer write did not redirect");
    a_ip_low_zero: assert property (rd_valid && $past(rd_addr) == A_IP |->
        rd_data[2:0] == 3'h0)
        else $error("pointer low bits not zero");
    a_pause_blocks: assert property (wr_en && wr_addr == A_PAUSE && wr_data[9:5] != 5'h00
        && !clr && !ctx_restore_active |=> issue_block)
        else $error("pause write did not block issue");
    a_clear_unblock: assert property (clr |=> !issue_block)
        else $error("clear event left issue blocked");
    a_pause_layout: assert property (rd_valid && $past(rd_addr) == A_PAUSE |->
        rd_data[31:10] == 22'h0 && rd_data[4:0] == 5'h00)
        else $error("pause read has bits outside count");
    a_flag_layout: assert property (rd_valid && $past(rd_addr) == A_EVT |->
        rd_data == {31'h0, ts_snapshot.discontinuity})
        else $error("flag word wrong");
    a_low_half: assert property (rd_valid && $past(rd_addr) == A_LO |->
        rd_data == ts_snapshot.lower_half)
        else $error("low half differs from snapshot");
    a_restore_flag: assert property (ctx_restore_begin ##1 (rd_en && rd_addr == A_EVT)
        |=> rd_data[0])
        else $error("restore did not set flag");
    c_redirect: cover property (redirect_valid);
    c_release: cover property ($fell(issue_block));
    c_flag_seen: cover property (rd_valid && rd_data[0] && $past(rd_addr) == A_EVT);
endmodule
bind thread_special_registers thread_regs_monitor u_mon (.clk, .rst, .rd_en, .rd_addr,
    .rd_valid, .rd_data, .ts_snapshot, .wr_en, .wr_addr, .wr_data, .redirect_valid,
    .redirect_addr, .thread_load, .sip_invoke, .ctx_save_begin, .ctx_restore_begin,
    .ctx_restore_active, .issue_block);

// ---- dv/issue_pipe_model.sv ----
// Issue pipeline model: issues while open, retires pause writes late
`timescale 1ns/1ps
module issue_pipe_model
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        run,
    input  wire logic        issue_block,
    input  wire logic        pause_issued,
    input  wire logic [7:0]  retire_lat,
    output logic             ip_update_en,
    output logic [31:0]      ip_update_val,
    output logic             pause_write_retire
);
    logic [7:0] wait_reg;
    // One instruction per clock, only while issue is open
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ip_update_en  <= 1'b0;
            ip_update_val <= 32'h0000_1000;
        end
        else
        begin
            ip_update_en <= run && !issue_block;
            if (run && !issue_block)
                ip_update_val <= ip_update_val + 32'h0000_0008;
        end
    end
    // In-flight pause write retires even while issue is blocked; 0 never retires
    always_ff @(posedge clk)
    begin
        if (rst)
            wait_reg <= 8'h00;
        else if (pause_issued)
            wait_reg <= retire_lat;
        else if (wait_reg != 8'h00)
            wait_reg <= wait_reg - 8'h01;
    end
    assign pause_write_retire = (wait_reg == 8'h01);
endmodule

// ---- dv/testbench.sv ----
// Self-checking bench for the per-thread special register file
`timescale 1ns/1ps
module testbench;
    import thread_regs_pkg::*;
    localparam arf_addr_type A_IP = '{TYPE_IP, NUM_ZERO, SUB_DW0};
    localparam arf_addr_type A_HOST = '{TYPE_NOTIFY, NUM_HOST, SUB_DW0};
    localparam arf_addr_type A_LO = '{TYPE_PERF, NUM_ZERO, SUB_DW0};
    localparam arf_addr_type A_HI = '{TYPE_PERF, NUM_ZERO, SUB_DW1};
    localparam arf_addr_type A_EVT = '{TYPE_PERF, NUM_ZERO, SUB_DW2};
    localparam arf_addr_type A_PM = '{TYPE_PERF, NUM_ZERO, SUB_DW3};
    localparam arf_addr_type A_PAUSE = '{TYPE_PERF, NUM_ZERO, SUB_DW4};
    logic clk, rst, rd_en, rd_valid, wr_en, redirect_valid, issue_block, run;
    logic thread_load, sip_invoke, ctx_save_begin, ctx_restore_begin, time_event;
    logic ctx_save_active, ctx_restore_active, host_notify_set, host_notify_consume;
    logic ts_tick_pin, perf_event, ip_update_en, pause_write_retire, pause_issued;
    logic [31:0] rd_data, wr_data, ip_update_val, dispatch_ip, redirect_addr, v, w;
    logic [7:0] retire_lat;
    arf_addr_type rd_addr, wr_addr;
    ts_snapshot_type ts_snapshot;
    int mismatches, checked, cycles, n;
    assign pause_issued = wr_en && (wr_addr == A_PAUSE);
    thread_special_registers u_dut (.clk, .rst, .rd_en, .rd_addr, .rd_valid, .rd_data,
        .ts_snapshot, .wr_en, .wr_addr, .wr_data, .pause_write_retire, .ip_update_en,
        .ip_update_val, .dispatch_ip, .redirect_valid, .redirect_addr, .thread_load,
        .sip_invoke, .ctx_save_begin, .ctx_restore_begin, .ctx_save_active,
        .ctx_restore_active, .time_event, .host_notify_set, .host_notify_consume,
        .ts_tick_pin, .perf_event, .issue_block);
    issue_pipe_model u_pipe (.clk, .rst, .run, .issue_block, .pause_issued, .retire_lat,
        .ip_update_en, .ip_update_val, .pause_write_retire);
    // ********
    // Clock, hang guard and bus tasks
    // ********
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Whole run needs under three hundred cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            summarize();
        end
    end
    task automatic step(int k = 1);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk(string name, logic [63:0] exp, logic [63:0] got);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    // Read answer is registered, so sample one edge after the request
    task automatic rd(arf_addr_type a, output logic [31:0] d);
        rd_en = 1'b1;
        rd_addr = a;
        step();
        rd_en = 1'b0;
        chk("rd_valid", 1, rd_valid);
        d = rd_data;
    endtask
    task automatic rdchk(string name, arf_addr_type a, logic [31:0] exp);
        rd(a, v);
        chk(name, exp, v);
    endtask
    task automatic wr(arf_addr_type a, logic [31:0] d);
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = d;
        step();
        wr_en = 1'b0;
    endtask
    task automatic summarize();
        $display("checked %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_reset_host();
        rdchk("ip reset", A_IP, IP_RESET);
        rdchk("perf reset", A_PM, PERF_RESET);
        rdchk("host reset", A_HOST, HOST_RESET);
        rdchk("unmapped", '{4'hB, 4'h0, 5'h00}, 32'h0000_0000);
        host_notify_set = 1'b1;
        step();
        host_notify_set = 1'b0;
        rdchk("host set", A_HOST, 32'h0000_0001);
        host_notify_consume = 1'b1;
        step();
        host_notify_consume = 1'b0;
        rdchk("host clear", A_HOST, 32'h0000_0000);
    endtask
    task automatic t_pointer();
        dispatch_ip = 32'h1234_567F;
        thread_load = 1'b1;
        step();
        thread_load = 1'b0;
        rdchk("ip dispatch", A_IP, 32'h1234_5678);
        wr(A_IP, 32'hABCD_EF07);
        chk("redirect", 1, redirect_valid);
        chk("redirect addr", 32'hABCD_EF00, redirect_addr);
        rdchk("ip written", A_IP, 32'hABCD_EF00);
    endtask
    task automatic pulse_event();
        time_event = 1'b1;
        step();
        time_event = 1'b0;
    endtask
    task automatic t_timestamp();
        // Slow ticks keep highs and lows well past the synchroniser
        repeat (5)
        begin
            ts_tick_pin = 1'b1;
            step(3);
            ts_tick_pin = 1'b0;
            step(3);
        end
        step(8);
        rdchk("ts low", A_LO, 32'h0000_0005);
        chk("snap low", 5, ts_snapshot.lower_half);
        rdchk("ts high", A_HI, 32'h0000_0000);
        chk("snap high", 0, ts_snapshot.upper_half);
        wr(A_LO, 32'hFFFF_FFFF);
        rdchk("ts kept", A_LO, 32'h0000_0005);
        pulse_event();
        rdchk("flag set", A_EVT, 32'h0000_0001);
        rdchk("flag read clr", A_EVT, 32'h0000_0000);
        pulse_event();
        rd(A_HI, w);
        rdchk("flag any half", A_EVT, 32'h0000_0000);
        pulse_event();
        thread_load = 1'b1;
        step();
        thread_load = 1'b0;
        rdchk("flag load clr", A_EVT, 32'h0000_0000);
        ctx_restore_begin = 1'b1;
        step();
        ctx_restore_begin = 1'b0;
        rdchk("flag restore", A_EVT, 32'h0000_0001);
        chk("snap flag", 1, ts_snapshot.discontinuity);
    endtask
    task automatic t_perf();
        rd(A_PM, w);
        perf_event = 1'b1;
        step(4);
        thread_load = 1'b1;
        step();
        thread_load = 1'b0;
        ctx_save_begin = 1'b1;
        step();
        ctx_save_begin = 1'b0;
        step(4);
        perf_event = 1'b0;
        wr(A_PM, 32'h0000_0000);
        rdchk("perf count", A_PM, w + 32'd10);
    endtask
    task automatic t_pause();
        run = 1'b1;
        wr(A_PAUSE, 32'h0000_0040);
        chk("block", 1, issue_block);
        // Let the advance issued alongside the write land first
        step();
        rd(A_IP, w);
        step(40);
        rd(A_IP, v);
        chk("ip held", w, v);
        chk("no retire", 1, issue_block);
        rdchk("pause value", A_PAUSE, 32'h0000_0040);
        retire_lat = 8'h03;
        wr(A_PAUSE, 32'h0000_0040);
        n = 0;
        while (issue_block === 1'b1 && n < 200)
        begin
            step();
            n++;
        end
        chk("release window", 1, n >= 32 && n <= 68);
        step(40);
        rdchk("halt at zero", A_PAUSE, 32'h0000_0000);
        rd(A_IP, w);
        rd(A_IP, v);
        chk("ip resumed", 1, v != w);
        retire_lat = 8'h00;
        wr(A_PAUSE, 32'h0000_FFFF);
        rdchk("pause field", A_PAUSE, 32'h0000_03E0);
        for (int i = 0; i < 4; i++)
        begin
            wr(A_PAUSE, 32'h0000_03E0);
            {thread_load, sip_invoke, ctx_save_begin, ctx_restore_begin} = 4'h8 >> i;
            step();
            {thread_load, sip_invoke, ctx_save_begin, ctx_restore_begin} = 4'h0;
            chk("cleared", 0, issue_block);
        end
        wr(A_PAUSE, 32'h0000_0040);
        ctx_save_active = 1'b1;
        rdchk("save read", A_PAUSE, 32'h0000_0000);
        ctx_save_active = 1'b0;
        sip_invoke = 1'b1;
        step();
        sip_invoke = 1'b0;
        ctx_restore_active = 1'b1;
        wr(A_PAUSE, 32'h0000_0040);
        chk("restore write", 0, issue_block);
        wr(A_HOST, 32'h0000_0001);
        rdchk("host restore", A_HOST, 32'h0000_0001);
        ctx_restore_active = 1'b0;
        run = 1'b0;
    endtask
    // ********
    // Main sequence
    // ********
    initial
    begin
        {rd_en, wr_en, run, thread_load, sip_invoke, ctx_save_begin} = '0;
        {ctx_restore_begin, time_event, ctx_save_active, ctx_restore_active} = '0;
        {host_notify_set, host_notify_consume, ts_tick_pin, perf_event} = '0;
        {rd_addr, wr_addr, wr_data, dispatch_ip, retire_lat} = '0;
        {mismatches, checked, cycles, n} = '0;
        rst = 1'b1;
        step(6);
        rst = 1'b0;
        t_reset_host();
        t_pointer();
        t_timestamp();
        t_perf();
        t_pause();
        summarize();
    end
endmodule
